// File: rtl/ecif_defines.vh
// Constants for the event channel port: channel count, clamp levels, sender states.
// Assumes it is included by bare name from every rtl file of the port.
`ifndef ECIF_DEFINES_VH
`define ECIF_DEFINES_VH

// ----------------------------------------------------------------------------
// Sizes and clamp values
// ----------------------------------------------------------------------------
`define ECIF_NUM_CH      4
`define ECIF_CLAMP_ACK   1'h1
`define ECIF_CLAMP_OUT   1'h0
`define ECIF_SYNC_RESET  1'h0

// ----------------------------------------------------------------------------
// Sender states
// ----------------------------------------------------------------------------
`define ECIF_ST_IDLE     2'h0
`define ECIF_ST_HIGH     2'h1
`define ECIF_ST_LOW      2'h2

`endif

// File: rtl/ecif_sync2.v
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit is a level that stays put long enough to be seen.
`timescale 1ns/1ps
`default_nettype none
`include "ecif_defines.vh"

module ecif_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             arst_n,
  // Levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] stable_r;

  // ----------------------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------------------
  // The first stage feeds only the second; nothing else may look at it.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_r   <= {WIDTH{`ECIF_SYNC_RESET}};
      stable_r <= {WIDTH{`ECIF_SYNC_RESET}};
    end else begin
      meta_r   <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;

endmodule // ecif_sync2

`default_nettype wire

// File: rtl/ecif_tx_chan.v
// One outgoing event channel: turns a local event level into line activity.
// Assumes ack_sync is already synchronised and tick marks a channel clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "ecif_defines.vh"

module ecif_tx_chan #(
  parameter ASYNC_MODE = 1
) (
  // Clock and reset
  input  wire clk_sys,
  input  wire arst_n,
  // Control
  input  wire enable,
  input  wire tick,
  // Local event source
  input  wire req_level,
  // Line
  input  wire ack_sync,
  output wire line_out,
  output wire busy
);

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg       line_r;
  reg       line_nxt;
  reg       req_d_r;
  reg       pend_r;
  reg       pend_nxt;
  wire      req_rise;

  assign req_rise = req_level & ~req_d_r;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    line_nxt  = line_r;
    // Rises seen while busy collapse into one pending event.
    pend_nxt  = pend_r | req_rise;
    case (state_r)
      `ECIF_ST_IDLE: begin
        // A peer may still acknowledge an event cut by a disable; wait for it to drop.
        if ((pend_r | req_rise) && tick && !((ASYNC_MODE != 0) && ack_sync)) begin
          line_nxt  = 1'h1;
          pend_nxt  = 1'h0;
          state_nxt = `ECIF_ST_HIGH;
        end
      end
      `ECIF_ST_HIGH: begin
        // Held while the local event lasts.
        if (ASYNC_MODE != 0) begin
          if (ack_sync && !req_level) begin
            line_nxt  = 1'h0;
            state_nxt = `ECIF_ST_LOW;
          end
        end else if (tick && !req_level) begin
          line_nxt  = 1'h0;
          state_nxt = `ECIF_ST_LOW;
        end
      end
      `ECIF_ST_LOW: begin
        // At least one low period before the next rise.
        if (ASYNC_MODE != 0) begin
          if (!ack_sync) begin
            state_nxt = `ECIF_ST_IDLE;
          end
        end else if (tick) begin
          state_nxt = `ECIF_ST_IDLE;
        end
      end
      default: begin
        line_nxt  = 1'h0;
        state_nxt = `ECIF_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= `ECIF_ST_IDLE;
      line_r  <= `ECIF_CLAMP_OUT;
      req_d_r <= 1'h0;
      pend_r  <= 1'h0;
    end else if (!enable) begin
      state_r <= `ECIF_ST_IDLE;
      line_r  <= `ECIF_CLAMP_OUT;
      req_d_r <= req_level;
      pend_r  <= 1'h0;
    end else begin
      state_r <= state_nxt;
      line_r  <= line_nxt;
      req_d_r <= req_level;
      pend_r  <= pend_nxt;
    end
  end

  assign line_out = line_r;
  assign busy     = (state_r != `ECIF_ST_IDLE) | pend_r;

endmodule // ecif_tx_chan

`default_nettype wire

// File: rtl/ecif_channel_port.v
// Event channel port of a debug component: N channels in and N channels out.
// Assumes channel pins come from another clock domain and local events are on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "ecif_defines.vh"

module ecif_channel_port #(
  parameter NUM_CH     = `ECIF_NUM_CH,
  parameter HAS_IN     = 1,
  parameter HAS_OUT    = 1,
  parameter ASYNC_MODE = 1
) (
  // Clock and reset
  input  wire              clk_sys,
  input  wire              arst_n,
  // Power and enable
  input  wire              port_enable,
  // Local event sources, one level per channel
  input  wire [NUM_CH-1:0] local_event_vec,
  // Received events and sender busy flags towards local logic
  output reg  [NUM_CH-1:0] rx_event_pulse_vec,
  output reg  [NUM_CH-1:0] rx_end_pulse_vec,
  output reg  [NUM_CH-1:0] rx_level_vec,
  output reg  [NUM_CH-1:0] tx_busy_vec,
  // Channel pins, numbered from 0 so a narrower peer joins the low channels.
  input  wire              channel_clock,
  input  wire [NUM_CH-1:0] channel_in_vec,
  output reg  [NUM_CH-1:0] channel_in_ack_vec,
  output wire [NUM_CH-1:0] channel_out_vec,
  input  wire [NUM_CH-1:0] channel_out_ack_vec
);

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  wire [NUM_CH-1:0] in_sync;
  wire [NUM_CH-1:0] out_ack_sync;
  wire              channel_clock_sync;
  reg               channel_clock_d_r;
  wire              tick;
  reg  [NUM_CH-1:0] in_prev_r;
  wire [NUM_CH-1:0] tx_line;
  wire [NUM_CH-1:0] tx_busy;

  ecif_sync2 #(.WIDTH(NUM_CH)) u_in_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .async_in (channel_in_vec),
    .sync_out (in_sync)
  );

  ecif_sync2 #(.WIDTH(NUM_CH)) u_ack_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .async_in (channel_out_ack_vec),
    .sync_out (out_ack_sync)
  );

  ecif_sync2 #(.WIDTH(1)) u_channel_clock_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .async_in (channel_clock),
    .sync_out (channel_clock_sync)
  );

  // ----------------------------------------------------------------------------
  // Channel clock edge
  // ----------------------------------------------------------------------------
  // The channel clock is sampled, so it must run well below clk_sys/2.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      channel_clock_d_r <= 1'h0;
    end else begin
      channel_clock_d_r <= channel_clock_sync;
    end
  end

  // The synchronous variant moves only on a channel clock rise.
  assign tick = (ASYNC_MODE != 0) ? 1'h1 : (channel_clock_sync & ~channel_clock_d_r);

  // ----------------------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------------------
  // Inputs feed only the rx outputs and acknowledges, never the senders.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      in_prev_r          <= {NUM_CH{1'h0}};
      rx_event_pulse_vec <= {NUM_CH{1'h0}};
      rx_end_pulse_vec   <= {NUM_CH{1'h0}};
      rx_level_vec       <= {NUM_CH{1'h0}};
      channel_in_ack_vec <= {NUM_CH{`ECIF_CLAMP_ACK}};
    end else if ((HAS_IN == 0) || !port_enable) begin
      in_prev_r          <= {NUM_CH{1'h0}};
      rx_event_pulse_vec <= {NUM_CH{1'h0}};
      rx_end_pulse_vec   <= {NUM_CH{1'h0}};
      rx_level_vec       <= {NUM_CH{1'h0}};
      channel_in_ack_vec <= {NUM_CH{`ECIF_CLAMP_ACK}};
    end else begin
      if (tick) begin
        in_prev_r          <= in_sync;
        rx_event_pulse_vec <= in_sync & ~in_prev_r;
        rx_end_pulse_vec   <= ~in_sync & in_prev_r;
        rx_level_vec       <= in_sync;
      end else begin
        rx_event_pulse_vec <= {NUM_CH{1'h0}};
        rx_end_pulse_vec   <= {NUM_CH{1'h0}};
      end
      // Acknowledge follows the synchronised request level; the synchronous build holds it at the clamp level.
      if (ASYNC_MODE != 0) begin
        channel_in_ack_vec <= in_sync;
      end else begin
        channel_in_ack_vec <= {NUM_CH{`ECIF_CLAMP_ACK}};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------------------
  // Every channel gets the same sender; no channel has a fixed purpose.
  genvar ch;
  generate
    if (HAS_OUT != 0) begin : g_out
      for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
        ecif_tx_chan #(.ASYNC_MODE(ASYNC_MODE)) u_tx (
          .clk_sys   (clk_sys),
          .arst_n    (arst_n),
          .enable    (port_enable),
          .tick      (tick),
          .req_level (local_event_vec[ch]),
          .ack_sync  (out_ack_sync[ch]),
          .line_out  (tx_line[ch]),
          .busy      (tx_busy[ch])
        );
      end
    end else begin : g_no_out
      assign tx_line = {NUM_CH{`ECIF_CLAMP_OUT}};
      assign tx_busy = {NUM_CH{1'h0}};
    end
  endgenerate

  assign channel_out_vec = tx_line;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_busy_vec <= {NUM_CH{1'h0}};
    end else begin
      tx_busy_vec <= tx_busy;
    end
  end

endmodule // ecif_channel_port

`default_nettype wire

// File: verification/ecif_port_checker.sv
// Assertions on the pins of the event channel port.
// Assumes protocol checks matter only in the asynchronous build with both directions.
`timescale 1ns/1ps
`default_nettype none
module ecif_port_checker #(
  parameter NUM_CH     = 4,
  parameter FULL_ASYNC = 1
) (
  // Watched ports
  input wire logic              clk_sys,
  input wire logic              arst_n,
  input wire logic              port_enable,
  input wire logic [NUM_CH-1:0] local_event_vec,
  input wire logic [NUM_CH-1:0] rx_event_pulse_vec,
  input wire logic [NUM_CH-1:0] rx_end_pulse_vec,
  input wire logic [NUM_CH-1:0] tx_busy_vec,
  input wire logic [NUM_CH-1:0] channel_in_vec,
  input wire logic [NUM_CH-1:0] channel_in_ack_vec,
  input wire logic [NUM_CH-1:0] channel_out_vec,
  input wire logic [NUM_CH-1:0] channel_out_ack_vec
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Input history restarts on enable, so the receive checks wait for eight enabled cycles.
  clamp_off_a: assert property ((!port_enable) [*2] |->
    channel_out_vec == '0 && &channel_in_ack_vec) else $error("clamp missing");
  if (FULL_ASYNC != 0) begin : g_full
  rx_rise_a: assert property (port_enable [*8] |-> rx_event_pulse_vec ==
    ($past(channel_in_vec, 3) & ~$past(channel_in_vec, 4))) else $error("event pulse");
  rx_end_a: assert property (port_enable [*8] |-> rx_end_pulse_vec ==
    (~$past(channel_in_vec, 3) & $past(channel_in_vec, 4))) else $error("end pulse");
  in_ack_a: assert property (port_enable [*8] |->
    channel_in_ack_vec == $past(channel_in_vec, 3)) else $error("input ack");
  tx_cause_a: assert property ((channel_out_vec & ~$past(channel_out_vec) &
    ~$past(local_event_vec) & ~$past(tx_busy_vec)) == '0) else $error("output cause");
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    tx_start_a: assert property ((port_enable && !tx_busy_vec[g] && !channel_out_ack_vec[g]) [*3] ##0
      $rose(local_event_vec[g]) |=> channel_out_vec[g]) else $error("send start");
    tx_hold_a: assert property ($fell(channel_out_vec[g]) && $past(port_enable) |->
      $past(channel_out_ack_vec[g], 3)) else $error("early drop");
    tx_wait_a: assert property ($rose(channel_out_vec[g]) |->
      !$past(channel_out_ack_vec[g], 3)) else $error("early raise");
  end
  end
endmodule // ecif_port_checker

bind ecif_channel_port ecif_port_checker #(.NUM_CH(NUM_CH),
  .FULL_ASYNC((ASYNC_MODE != 0) && (HAS_IN != 0) && (HAS_OUT != 0))) u_chk (.clk_sys, .arst_n,
  .port_enable, .local_event_vec, .rx_event_pulse_vec, .rx_end_pulse_vec, .tx_busy_vec,
  .channel_in_vec, .channel_in_ack_vec, .channel_out_vec, .channel_out_ack_vec);
`default_nettype wire

// File: verification/ecif_peer_model.sv
// Peer port model: acknowledges the design's outputs and sends it events.
// Assumes requests are levels from the bench; ack_wait sets the answer delay.
`timescale 1ns/1ps
`default_nettype none
module ecif_peer_model #(
  parameter NUM_CH = 4
) (
  // Clock, reset and bench control
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic [NUM_CH-1:0] peer_req_vec,
  input  wire logic [7:0]        ack_wait,
  // Link
  input  wire logic [NUM_CH-1:0] channel_out_vec,
  output var  logic [NUM_CH-1:0] channel_out_ack_vec,
  output var  logic [NUM_CH-1:0] channel_in_vec,
  input  wire logic [NUM_CH-1:0] channel_in_ack_vec
);
  logic [7:0] cnt_r [NUM_CH];
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      channel_out_ack_vec <= '0;
      channel_in_vec <= '0;
      for (int i = 0; i < NUM_CH; i++) cnt_r[i] <= 8'h00;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        // A slow answer lets the design's hold be seen.
        if (channel_out_vec[i] == channel_out_ack_vec[i]) cnt_r[i] <= 8'h00;
        else if (cnt_r[i] < ack_wait) cnt_r[i] <= cnt_r[i] + 8'h01;
        else channel_out_ack_vec[i] <= channel_out_vec[i];
        // Rise starts an event, high holds it, next only after ack low.
        if (peer_req_vec[i] && !channel_in_vec[i] && !channel_in_ack_vec[i])
          channel_in_vec[i] <= 1'b1;
        else if (channel_in_vec[i] && channel_in_ack_vec[i] && !peer_req_vec[i])
          channel_in_vec[i] <= 1'b0;
      end
    end
  end
endmodule // ecif_peer_model
`default_nettype wire

// File: verification/ecif_channel_port_tb.sv
// Bench for the event channel port against the peer model.
// Assumes the default asynchronous build, plus a synchronous input-only build beside it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
`define WT(n, s, v) begin #1; \
  for (k = 0; k < 300 && (s) !== (v); k++) @(posedge clk_sys) #1; \
  `CHK(n, v, s) if (k == 300) end_sim; end
module ecif_channel_port_tb;
  logic        clk_sys = 1'b0, arst_n = 1'b0, port_enable = 1'b1;
  logic [3:0]  local_event_vec = 4'h0, peer_req_vec = 4'h0, m;
  logic [7:0]  ack_wait = 8'h00;
  wire  [3:0]  rx_event_pulse_vec, rx_end_pulse_vec, tx_busy_vec, channel_in_vec;
  wire  [3:0]  rx_level_vec, s_pulse_vec, s_level_vec, s_busy_vec, s_ack_vec, s_out_vec;
  logic [3:0]  s_in_vec = 4'h0;
  logic        s_clock = 1'b0;
  wire  [3:0]  channel_in_ack_vec, channel_out_vec, channel_out_ack_vec;
  int          miscompares = 0, n_compared = 0, r, k;
  // Peer answer delay, then the one channel used in both directions.
  logic [11:0] rows [4] = '{12'h001, 12'h052, 12'h004, 12'h058};
  always #2 clk_sys = ~clk_sys;
  ecif_channel_port u_dut (.clk_sys, .arst_n, .port_enable, .local_event_vec,
    .rx_event_pulse_vec, .rx_end_pulse_vec, .rx_level_vec, .tx_busy_vec,
    .channel_clock(1'b0), .channel_in_vec, .channel_in_ack_vec, .channel_out_vec,
    .channel_out_ack_vec);
  ecif_peer_model u_peer (.clk_sys, .arst_n, .peer_req_vec, .ack_wait, .channel_out_vec,
    .channel_out_ack_vec, .channel_in_vec, .channel_in_ack_vec);
  ecif_channel_port #(.HAS_OUT(0), .ASYNC_MODE(0)) u_dut_sync (.clk_sys, .arst_n,
    .port_enable, .local_event_vec, .rx_event_pulse_vec(s_pulse_vec), .rx_end_pulse_vec(),
    .rx_level_vec(s_level_vec), .tx_busy_vec(s_busy_vec), .channel_clock(s_clock),
    .channel_in_vec(s_in_vec), .channel_in_ack_vec(s_ack_vec), .channel_out_vec(s_out_vec),
    .channel_out_ack_vec(4'h0));
  task end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    `CHK("reset out", 4'h0, channel_out_vec)
    `CHK("reset ack", 4'hF, channel_in_ack_vec)
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (r = 0; r < 4; r++) begin
      m = rows[r][3:0];
      @(posedge clk_sys);
      ack_wait <= rows[r][11:4];
      peer_req_vec <= m;
      `WT("rx event", rx_event_pulse_vec, m)
      `CHK("in ack", m, channel_in_ack_vec)
      `CHK("loopback", 4'h0, channel_out_vec)
      `CHK("rx level", m, rx_level_vec)
      @(posedge clk_sys);
      peer_req_vec <= 4'h0;
      `WT("rx end", rx_end_pulse_vec, m)
      `CHK("rx level low", 4'h0, rx_level_vec)
      @(posedge clk_sys);
      local_event_vec <= m;
      `WT("tx out", channel_out_vec, m)
      @(posedge clk_sys);
      local_event_vec <= 4'h0;
      `WT("tx drop", channel_out_vec, 4'h0)
    end
    // A lasting event keeps the line up even after the peer has answered.
    @(posedge clk_sys);
    ack_wait <= 8'h00;
    local_event_vec <= 4'h2;
    `WT("out ack", channel_out_ack_vec, 4'h2)
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK("held", 4'h2, channel_out_vec)
    @(posedge clk_sys);
    port_enable <= 1'b0;
    `WT("clamp out", channel_out_vec, 4'h0)
    `WT("clamp ack", channel_in_ack_vec, 4'hF)
    @(posedge clk_sys);
    local_event_vec <= 4'h0;
    port_enable <= 1'b1;
    `WT("peer ack low", channel_out_ack_vec, 4'h0)
    `WT("idle", tx_busy_vec, 4'h0)
    `CHK("no resend", 4'h0, channel_out_vec)
    // Reset in mid-event must clear the line at once.
    @(posedge clk_sys);
    local_event_vec <= 4'h4;
    `WT("pre reset", channel_out_vec, 4'h4)
    @(posedge clk_sys);
    arst_n <= 1'b0;
    local_event_vec <= 4'h0;
    #1;
    `CHK("mid reset out", 4'h0, channel_out_vec)
    `CHK("mid reset ack", 4'hF, channel_in_ack_vec)
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("after reset", 4'h0, channel_out_vec | tx_busy_vec)
    // Synchronous input-only build: inputs move only on a channel clock rise.
    @(posedge clk_sys);
    s_in_vec <= 4'h3;
    local_event_vec <= 4'hF;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("sync no tick", 4'h0, s_level_vec)
    @(posedge clk_sys);
    s_clock <= 1'b1;
    `WT("sync event", s_pulse_vec, 4'h3)
    `CHK("sync level", 4'h3, s_level_vec)
    `CHK("sync ack", 4'hF, s_ack_vec)
    `CHK("sync out", 4'h0, s_out_vec)
    `CHK("sync busy", 4'h0, s_busy_vec)
    end_sim;
  end
endmodule // ecif_channel_port_tb
`default_nettype wire
